// File: pkg/ccr_pkg.sv
`default_nettype none
package ccr_pkg;
  // register byte addresses
  localparam logic [11:0] REF_CTRL_ADDR = 12'h20C;
  localparam logic [11:0] CMP1_MAIN_ADDR = 12'h80C;
  localparam logic [11:0] CMP1_EDGE_ADDR = 12'h80D;
  localparam logic [11:0] CMP1_NEG_ADDR = 12'h80E;
  localparam logic [11:0] CMP1_POS_ADDR = 12'h80F;
  localparam logic [11:0] CMP2_MAIN_ADDR = 12'h810;
  localparam logic [11:0] CMP2_EDGE_ADDR = 12'h811;
  localparam logic [11:0] CMP2_NEG_ADDR = 12'h812;
  localparam logic [11:0] CMP2_POS_ADDR = 12'h813;
  localparam logic [11:0] OUT_MIRROR_ADDR = 12'h81F;
  localparam logic [11:0] IRQ_STAT_ADDR = 12'h820;
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h821;
  // field positions
  localparam int MAIN_EN_BIT = 7;
  localparam int MAIN_OUT_BIT = 6;
  localparam int MAIN_POL_BIT = 4;
  localparam int MAIN_HYS_BIT = 1;
  localparam int MAIN_SYNC_BIT = 0;
  localparam int RISE_EN_BIT = 1;
  localparam int FALL_EN_BIT = 0;
  localparam int REF_EN_BIT = 7;
  localparam int REF_RDY_BIT = 6;
  localparam int TEMP_ON_BIT = 5;
  localparam int TEMP_RNG_BIT = 4;
  localparam int BUF2_LSB = 2;
  localparam int BUF1_LSB = 0;
  // reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  // settling time of the reference
  localparam int REF_SETTLE_NS = 25000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int REF_SETTLE_CYC =
    (REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // source selector binary codes
  localparam logic [2:0] SEL_NONE = 3'h4;
  localparam logic [2:0] SEL_GND = 3'h7;

  typedef struct packed {
    logic [1:0] gain;
  } ccr_buf_t;

  typedef struct packed {
    logic [3:0] neg_pin;   // external inverting pins 0..3
    logic neg_opamp;
    logic neg_buf2;
    logic neg_gnd;
    logic pos_pin0;
    logic pos_conv1;
    logic pos_conv2;
    logic pos_buf2;
    logic pos_gnd;
  } ccr_route_t;

  typedef enum logic [1:0] {
    REF_OFF = 2'b00,
    REF_SETTLE = 2'b01,
    REF_READY = 2'b11
  } ccr_ref_state_t;
endpackage : ccr_pkg
`default_nettype wire

// File: logic/ccr_top.sv
// Function
// RQ1: rise enable set: a low-to-high result edge sets that comparator's flag.
// RQ2: fall enable set: a high-to-low result edge sets that comparator's flag.
// RQ3: inverting select: 0-3 pins, 4 none, 5 op-amp, 6 buffer two, 7 ground.
// RQ4: noninverting select: 0 pin, 1-3 none, 4/5 converters, 6 buffer two, 7 gnd.
// RQ5: on the smallest package, external pin sources are never selected.
// RQ6: output mirror shows comparator 1 at bit 0, comparator 2 at bit 1.
// RQ7: reference enable bit 7 turns the fixed reference on or off.
// RQ8: ready bit 6 reads 1 only after the enabled reference settled.
// RQ9: buffer two gain at bits 3:2: off, 1x, 2x, 4x.
// RQ10: buffer one gain at bits 1:0: off, 1x, 2x, 4x.
// RQ11: buffer one feeds converter reference and input; buffer two the rest.
// RQ12: bit 5 turns the temperature indicator on.
// RQ13: bit 4 picks temperature range: 1 high, 0 low.
// RQ14: reference and temperature fields share one register byte.
// RQ15: software clears a flag before another edge is reported.
// RQ16: result bit is comparison xor invert; invert change also makes an edge.
// RQ17: edges found from synchronised result versus its previous-cycle copy.
//
// Local design decision: strobed register access.
`default_nettype none
module ccr_top
  import ccr_pkg::*;
#(
  parameter bit SMALL_PKG = 1'b0,
  parameter int SETTLE_CYC = REF_SETTLE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [1:0] cmp_raw_i,
  input wire logic ref_settled_i,
  output logic irq_o,
  output logic [1:0] cmp_edge_flag_o,
  output logic [1:0] cmp_en_o,
  output logic [1:0] cmp_hys_o,
  output logic [1:0] cmp_sync_o,
  output ccr_route_t [1:0] route_o,
  output logic ref_on_o,
  output ccr_buf_t buf1_o,
  output ccr_buf_t buf2_o,
  output logic buf1_to_adc_ref_o,
  output logic buf1_to_adc_in_o,
  output logic buf2_to_cmp_dac_o,
  output logic buf2_to_adc_in_o,
  output logic temp_sense_on_o,
  output logic temp_range_sel_o
);

  logic [7:0] main_q [2], main_d [2];
  logic [1:0] edge_en_q [2], edge_en_d [2];
  logic [2:0] neg_q [2], neg_d [2];
  logic [2:0] pos_q [2], pos_d [2];
  logic [7:0] ref_q, ref_d;
  logic [1:0] stat_q, stat_d, mask_q, mask_d;
  logic [7:0] rdata_q, rdata_d;
  logic [1:0] s1_q, s2_q, s3_q, raw_q;
  logic [1:0] res_q, res_d, prev_q;
  logic [1:0] rise_ev, fall_ev, edge_ev;
  ccr_ref_state_t st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic [2:0] rs1_q;
  logic rdy_raw_q;
  ccr_route_t route_d [2];
  ccr_route_t [1:0] route_q;

  // three-stage synchroniser; a change counts when stages two and three agree
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
      s3_q <= 2'h0;
      raw_q <= 2'h0;
      rs1_q <= 3'h0;
      rdy_raw_q <= 1'b0;
    end else begin
      s1_q <= cmp_raw_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      raw_q <= (s2_q & s3_q) | (raw_q & (s2_q | s3_q));
      rs1_q <= {rs1_q[1:0], ref_settled_i};
      if (rs1_q[1] == rs1_q[2]) begin
        rdy_raw_q <= rs1_q[2];
      end
    end
  end

  // polarity applied after sync; edges versus previous cycle
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      res_d[i] = raw_q[i] ^ main_q[i][MAIN_POL_BIT]; // [RQ16] [RQ17]
    end
    rise_ev = res_q & ~prev_q;
    fall_ev = ~res_q & prev_q;
    for (int i = 0; i < 2; i++) begin
      edge_ev[i] = (rise_ev[i] & edge_en_q[i][RISE_EN_BIT])    // [RQ1]
        | (fall_ev[i] & edge_en_q[i][FALL_EN_BIT]);           // [RQ2]
    end
  end

  // reference settle state machine
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      REF_OFF: begin
        cnt_d = 16'h0000;
        if (ref_q[REF_EN_BIT]) st_d = REF_SETTLE; // [RQ7]
      end
      REF_SETTLE: begin
        if (!ref_q[REF_EN_BIT]) begin
          st_d = REF_OFF;
        end else if (cnt_q >= 16'(SETTLE_CYC - 1) && rdy_raw_q) begin
          st_d = REF_READY; // [RQ8]
        end else if (cnt_q < 16'(SETTLE_CYC - 1)) begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      REF_READY: begin
        if (!ref_q[REF_EN_BIT] || !rdy_raw_q) st_d = REF_OFF; // [RQ8]
      end
      default: st_d = REF_OFF;
    endcase
  end

  // register writes, sticky flags and read data
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      main_d[i] = main_q[i];
      edge_en_d[i] = edge_en_q[i];
      neg_d[i] = neg_q[i];
      pos_d[i] = pos_q[i];
    end
    ref_d = ref_q;
    mask_d = mask_q;
    stat_d = stat_q;
    rdata_d = 8'h00;
    if (wr_i) begin
      case (addr_i)
        CMP1_MAIN_ADDR: main_d[0] = wdata_i & 8'h93;
        CMP2_MAIN_ADDR: main_d[1] = wdata_i & 8'h93;
        CMP1_EDGE_ADDR: edge_en_d[0] = wdata_i[1:0];
        CMP2_EDGE_ADDR: edge_en_d[1] = wdata_i[1:0];
        CMP1_NEG_ADDR: neg_d[0] = wdata_i[2:0];
        CMP2_NEG_ADDR: neg_d[1] = wdata_i[2:0];
        CMP1_POS_ADDR: pos_d[0] = wdata_i[2:0];
        CMP2_POS_ADDR: pos_d[1] = wdata_i[2:0];
        REF_CTRL_ADDR: ref_d = wdata_i & 8'hBF; // [RQ14]
        IRQ_MASK_ADDR: mask_d = wdata_i[1:0];
        default: ;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        CMP1_MAIN_ADDR: rdata_d = {main_q[0][7], res_q[0], main_q[0][5:0]};
        CMP2_MAIN_ADDR: rdata_d = {main_q[1][7], res_q[1], main_q[1][5:0]};
        CMP1_EDGE_ADDR: rdata_d = {6'h00, edge_en_q[0]};
        CMP2_EDGE_ADDR: rdata_d = {6'h00, edge_en_q[1]};
        CMP1_NEG_ADDR: rdata_d = {5'h00, neg_q[0]};
        CMP2_NEG_ADDR: rdata_d = {5'h00, neg_q[1]};
        CMP1_POS_ADDR: rdata_d = {5'h00, pos_q[0]};
        CMP2_POS_ADDR: rdata_d = {5'h00, pos_q[1]};
        OUT_MIRROR_ADDR: rdata_d = {6'h00, res_q}; // [RQ6]
        REF_CTRL_ADDR: rdata_d = {ref_q[REF_EN_BIT],
          st_q == REF_READY && ref_q[REF_EN_BIT],
          ref_q[5:0]}; // [RQ8] [RQ14]
        IRQ_STAT_ADDR: begin
          rdata_d = {6'h00, stat_q};
          stat_d = 2'h0; // read clears [RQ15]
        end
        IRQ_MASK_ADDR: rdata_d = {6'h00, mask_q};
        default: rdata_d = 8'h00;
      endcase
    end
    stat_d = stat_d | edge_ev; // set wins over clear [RQ1] [RQ2]
  end

  // channel decode, one selector pair per comparator
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      route_d[i] = '0;
      if (main_q[i][MAIN_EN_BIT]) begin
        case (neg_q[i])
          3'h0, 3'h1, 3'h2, 3'h3: route_d[i].neg_pin[neg_q[i][1:0]] =
            !SMALL_PKG; // [RQ3] [RQ5]
          SEL_NONE: ;
          3'h5: route_d[i].neg_opamp = 1'b1;
          3'h6: route_d[i].neg_buf2 = 1'b1;
          SEL_GND: route_d[i].neg_gnd = 1'b1;
          default: ;
        endcase
        case (pos_q[i])
          3'h0: route_d[i].pos_pin0 = !SMALL_PKG; // [RQ4] [RQ5]
          3'h4: route_d[i].pos_conv1 = 1'b1;
          3'h5: route_d[i].pos_conv2 = 1'b1;
          3'h6: route_d[i].pos_buf2 = 1'b1;
          SEL_GND: route_d[i].pos_gnd = 1'b1;
          default: ;
        endcase
      end
    end
  end

  // register everything
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 2; i++) begin
        main_q[i] <= REG_RESET;
        edge_en_q[i] <= 2'h0;
        neg_q[i] <= 3'h0;
        pos_q[i] <= 3'h0;
      end
      ref_q <= REG_RESET;
      stat_q <= 2'h0;
      mask_q <= 2'h0;
      rdata_q <= 8'h00;
      res_q <= 2'h0;
      prev_q <= 2'h0;
      st_q <= REF_OFF;
      cnt_q <= 16'h0000;
      route_q <= '0;
      irq_o <= 1'b0;
      cmp_edge_flag_o <= 2'h0;
      cmp_en_o <= 2'h0;
      cmp_hys_o <= 2'h0;
      cmp_sync_o <= 2'h0;
      ref_on_o <= 1'b0;
      buf1_o <= '0;
      buf2_o <= '0;
      buf1_to_adc_ref_o <= 1'b0;
      buf1_to_adc_in_o <= 1'b0;
      buf2_to_cmp_dac_o <= 1'b0;
      buf2_to_adc_in_o <= 1'b0;
      temp_sense_on_o <= 1'b0;
      temp_range_sel_o <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        main_q[i] <= main_d[i];
        edge_en_q[i] <= edge_en_d[i];
        neg_q[i] <= neg_d[i];
        pos_q[i] <= pos_d[i];
        route_q[i] <= route_d[i];
        cmp_en_o[i] <= main_d[i][MAIN_EN_BIT];
        cmp_hys_o[i] <= main_d[i][MAIN_HYS_BIT];
        cmp_sync_o[i] <= main_d[i][MAIN_SYNC_BIT];
      end
      ref_q <= ref_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      res_q <= res_d;
      prev_q <= res_q; // [RQ17]
      st_q <= st_d;
      cnt_q <= cnt_d;
      irq_o <= |(stat_d & mask_d);
      cmp_edge_flag_o <= stat_d;
      ref_on_o <= ref_d[REF_EN_BIT]; // [RQ7]
      buf1_o.gain <= ref_d[BUF1_LSB +: 2]; // [RQ10]
      buf2_o.gain <= ref_d[BUF2_LSB +: 2]; // [RQ9]
      buf1_to_adc_ref_o <= |ref_d[BUF1_LSB +: 2]; // [RQ11]
      buf1_to_adc_in_o <= |ref_d[BUF1_LSB +: 2]; // [RQ11]
      buf2_to_cmp_dac_o <= |ref_d[BUF2_LSB +: 2]; // [RQ11]
      buf2_to_adc_in_o <= |ref_d[BUF2_LSB +: 2]; // [RQ11]
      temp_sense_on_o <= ref_d[TEMP_ON_BIT]; // [RQ12]
      temp_range_sel_o <= ref_d[TEMP_RNG_BIT]; // [RQ13]
    end
  end
  assign rdata_o = rdata_q;
  assign route_o = route_q;

  // a result edge with its enable shows on the flag one cycle later
  rise_flag_a: assert property ( // [RQ1]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (rise_ev[0] && edge_en_q[0][RISE_EN_BIT]) |=> cmp_edge_flag_o[0])
    else $error("rise edge did not set flag");
  fall_flag_a: assert property ( // [RQ2]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (fall_ev[1] && edge_en_q[1][FALL_EN_BIT]) |=> cmp_edge_flag_o[1])
    else $error("fall edge did not set flag");
  no_flag_a: assert property ( // [RQ15]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (!stat_q[0] && !edge_ev[0] && !(rd_i && addr_i == IRQ_STAT_ADDR))
    |=> !stat_q[0])
    else $error("flag set without edge");
  stat_clear_a: assert property ( // [RQ15]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == IRQ_STAT_ADDR && !edge_ev[0]) |=> !stat_q[0])
    else $error("status read did not clear flag");
  edge_pulse_a: assert property ( // [RQ17]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    rise_ev[0] |=> !rise_ev[0])
    else $error("edge event longer than one cycle");
  mirror_bits_a: assert property ( // [RQ6]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == OUT_MIRROR_ADDR) |=> rdata_o == {6'h00, $past(res_q)})
    else $error("mirror read wrong");
  rdata_idle_a: assert property ( // strobed register access
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read cycle");
  ready_off_a: assert property ( // [RQ8]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !ref_q[REF_EN_BIT] |=> st_q != REF_READY)
    else $error("ready while disabled");
  ready_bit_a: assert property ( // [RQ8]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == REF_CTRL_ADDR && !ref_q[REF_EN_BIT])
    |=> !rdata_o[REF_RDY_BIT])
    else $error("ready bit read high while disabled");
  ref_enable_a: assert property ( // [RQ7]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == REF_CTRL_ADDR) |=> ref_on_o == $past(wdata_i[7]))
    else $error("reference enable not applied");
  gain_bits_a: assert property ( // [RQ9] [RQ10]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == REF_CTRL_ADDR) |=> buf2_o.gain == $past(wdata_i[3:2])
    && buf1_o.gain == $past(wdata_i[1:0]))
    else $error("buffer gains wrong");
  buf_route_a: assert property ( // [RQ11]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    buf1_to_adc_ref_o == (buf1_o.gain != 2'b00)
    && buf1_to_adc_in_o == (buf1_o.gain != 2'b00)
    && buf2_to_cmp_dac_o == (buf2_o.gain != 2'b00)
    && buf2_to_adc_in_o == (buf2_o.gain != 2'b00))
    else $error("buffer routing wrong");
  gnd_route_a: assert property ( // [RQ3]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (main_q[0][MAIN_EN_BIT] && neg_q[0] == SEL_GND) |=> route_o[0].neg_gnd)
    else $error("ground not routed");
  pos_gnd_a: assert property ( // [RQ4]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (main_q[1][MAIN_EN_BIT] && pos_q[1] == SEL_GND) |=> route_o[1].pos_gnd)
    else $error("positive ground not routed");
  route_off_a: assert property ( // [RQ3]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !main_q[0][MAIN_EN_BIT] |=> route_o[0] == '0)
    else $error("disabled comparator has a route");
  small_pin_a: assert property ( // [RQ5]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    SMALL_PKG |-> (route_o[0].neg_pin == 4'h0 && route_o[1].neg_pin == 4'h0
    && !route_o[0].pos_pin0 && !route_o[1].pos_pin0))
    else $error("pin routed on small package");
  temp_bits_a: assert property ( // [RQ12] [RQ13]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == REF_CTRL_ADDR) |=> temp_sense_on_o == $past(wdata_i[5])
    && temp_range_sel_o == $past(wdata_i[4]))
    else $error("temperature bits wrong");
  pol_edge_a: assert property ( // [RQ16]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    $changed(main_q[0][MAIN_POL_BIT]) && $stable(raw_q[0])
    |=> $changed(res_q[0]))
    else $error("polarity change made no edge");

endmodule // ccr_top
`default_nettype wire

// File: verif/comparator_and_reference_control_tb.sv
`default_nettype none
module comparator_and_reference_control_tb import ccr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, wr, rd, settled, rd_seen, irq, ref_on, ts_on, ts_rng;
  logic b1ref, b1in, b2cmp, b2in;
  logic [11:0] addr;
  logic [7:0] wdata, rdata, v;
  logic [1:0] raw, flag, cen, chys, csync;
  ccr_route_t [1:0] route, route_s;
  ccr_buf_t buf1, buf2;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h14C6;
  int n_errors = 0;
  int comparisons = 0;
  int g;

  ccr_top #(.SETTLE_CYC(4)) i_dut (.ref_clk_i(clk), .rst_n_i(rst_n),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .cmp_raw_i(raw), .ref_settled_i(settled), .irq_o(irq),
    .cmp_edge_flag_o(flag), .cmp_en_o(cen), .cmp_hys_o(chys),
    .cmp_sync_o(csync), .route_o(route), .ref_on_o(ref_on), .buf1_o(buf1),
    .buf2_o(buf2), .buf1_to_adc_ref_o(b1ref), .buf1_to_adc_in_o(b1in),
    .buf2_to_cmp_dac_o(b2cmp), .buf2_to_adc_in_o(b2in),
    .temp_sense_on_o(ts_on), .temp_range_sel_o(ts_rng));

  // small package variant on the same bus: only its routes are watched
  ccr_top #(.SMALL_PKG(1'b1), .SETTLE_CYC(4)) i_dut_small (.ref_clk_i(clk),
    .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(), .cmp_raw_i(raw), .ref_settled_i(settled), .irq_o(),
    .cmp_edge_flag_o(), .cmp_en_o(), .cmp_hys_o(), .cmp_sync_o(),
    .route_o(route_s), .ref_on_o(), .buf1_o(), .buf2_o(),
    .buf1_to_adc_ref_o(), .buf1_to_adc_in_o(), .buf2_to_cmp_dac_o(),
    .buf2_to_adc_in_o(), .temp_sense_on_o(), .temp_range_sel_o());

  // clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected one-hot sources for one select code on both inputs
  function automatic ccr_route_t rexp(input logic [2:0] k);
    rexp.neg_pin = (k < 3'h4) ? 4'h1 << k[1:0] : 4'h0;
    rexp.neg_opamp = (k == 3'h5);
    rexp.neg_buf2 = (k == 3'h6);
    rexp.neg_gnd = (k == 3'h7);
    rexp.pos_pin0 = (k == 3'h0);
    rexp.pos_conv1 = (k == 3'h4);
    rexp.pos_conv2 = (k == 3'h5);
    rexp.pos_buf2 = (k == 3'h6);
    rexp.pos_gnd = (k == 3'h7);
  endfunction

  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read strobe, expected data noted for the monitor
  task automatic rd_reg(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_seen <= rd;
    if (rd_seen && exp_q.size() > 0)
      chk(16'(rdata), 16'(exp_q.pop_front()));
  end

  task automatic idle();
    repeat (12) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic set_raw(input int c, input logic b);
    @(posedge clk);
    raw[c] <= b;
    idle();
  endtask

  // edge flags, mask, status clear, polarity and routing of one comparator
  task automatic cmp_test(input int c);
    logic [11:0] ma;
    logic [7:0] bit_c;
    logic [2:0] r;
    ccr_route_t e;
    ma = CMP1_MAIN_ADDR + 12'(4 * c);
    bit_c = 8'(1 << c);
    r = 3'(xs());
    wr_reg(IRQ_MASK_ADDR, 8'h03);
    wr_reg(ma, 8'h83);
    wr_reg(ma + 12'h1, 8'h02);
    wr_reg(ma + 12'h2, {5'h00, r});
    rd_reg(ma + 12'h2, {5'h00, r});
    @(negedge clk);
    chk(16'({cen[c], chys[c], csync[c]}), 16'h0007);
    for (int k = 0; k < 8; k++) begin
      wr_reg(ma + 12'h2, 8'(k));
      wr_reg(ma + 12'h3, 8'(k));
      // routes are registered from the stored selects: one more edge
      @(posedge clk);
      @(negedge clk);
      e = rexp(3'(k));
      chk(16'(route[c]), 16'(e));
      e.neg_pin = 4'h0;
      e.pos_pin0 = 1'b0;
      chk(16'(route_s[c]), 16'(e));
    end
    set_raw(c, 1'b1);
    chk(16'({irq, flag[c]}), 16'h0003);
    rd_reg(ma, 8'hC3);
    rd_reg(OUT_MIRROR_ADDR, bit_c);
    wr_reg(IRQ_MASK_ADDR, 8'h00);
    @(negedge clk);
    chk(16'(irq), 16'h0000);
    rd_reg(IRQ_STAT_ADDR, bit_c);
    set_raw(c, 1'b0);
    chk(16'(flag[c]), 16'h0000);
    wr_reg(ma + 12'h1, 8'h01);
    wr_reg(IRQ_MASK_ADDR, 8'h03);
    set_raw(c, 1'b1);
    chk(16'(flag[c]), 16'h0000);
    set_raw(c, 1'b0);
    chk(16'({irq, flag[c]}), 16'h0003);
    rd_reg(IRQ_STAT_ADDR, bit_c);
    @(negedge clk);
    chk(16'({irq, flag[c]}), 16'h0000);
    // disabled comparator: a polarity flip alone must make an edge
    wr_reg(ma + 12'h1, 8'h03);
    wr_reg(ma, 8'h10);
    idle();
    chk(16'({flag[c], route[c]}), 16'h1000);
    rd_reg(ma, 8'h50);
    rd_reg(IRQ_STAT_ADDR, bit_c);
    wr_reg(ma, 8'h00);
    idle();
    rd_reg(IRQ_STAT_ADDR, bit_c);
  endtask

  initial begin
    rst_n = 1'b0;
    {wr, rd, raw, addr, wdata} = '0;
    settled = 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, unmapped gaps read zero
    rd_reg(REF_CTRL_ADDR, 8'h00);
    for (int a = 12'h80C; a <= 12'h821; a++) rd_reg(12'(a), 8'h00);
    // reference enable, settle, gains, temperature bits
    wr_reg(REF_CTRL_ADDR, 8'h80);
    rd_reg(REF_CTRL_ADDR, 8'h80);
    repeat (30) @(posedge clk);
    rd_reg(REF_CTRL_ADDR, 8'hC0);
    // analog side loses its settled state: ready must drop, then return
    settled <= 1'b0;
    repeat (8) @(posedge clk);
    rd_reg(REF_CTRL_ADDR, 8'h80);
    settled <= 1'b1;
    repeat (12) @(posedge clk);
    for (g = 0; g < 4; g++) begin
      v = {2'b10, 2'(g), 2'(g), 2'(3 - g)};
      wr_reg(REF_CTRL_ADDR, v);
      @(negedge clk);
      chk(16'({ref_on, ts_on, ts_rng, buf2, buf1}),
          16'({v[7], v[5:0]}));
      chk(16'({b1ref, b1in, b2cmp, b2in}),
          16'({{2{g != 3}}, {2{g != 0}}}));
      rd_reg(REF_CTRL_ADDR, v | 8'h40);
    end
    wr_reg(REF_CTRL_ADDR, 8'h40);
    rd_reg(REF_CTRL_ADDR, 8'h00);
    @(negedge clk);
    chk(16'(ref_on), 16'h0000);
    cmp_test(0);
    cmp_test(1);
    repeat (3) @(posedge clk);
    wrap_up();
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
endmodule // comparator_and_reference_control_tb
`default_nettype wire
